// ---- src/rfc_core.sv ----
// Purpose: Reciprocal frequency counter with APB registers.
// Assumes: Trigger inputs are conditioned comparator outputs, asynchronous.
// Notes: Gate time is reported in resolution units; software divides.
//
// Summary of operation
// - Gate opens on first trigger after start
// - Gate closes on trigger after time elapsed
// - Cycles and gate time counted together
// - Gate time in 250 or 50 ps units
// - Scaled cycle result multiplied by division factor; raw count kept unscaled
// - Factors 2/4 for A, 16/32 for C
// - Negative slope on A bypasses prescaler
// - Single mode gates one prescaled cycle
// - Lost signal keeps previous result
// - Timeout selectable, default off, clamped range
// - Timeout without trigger flags absent input
// - Weak high-band input blocks prescaler output
// - Measurement lasts at least one prescaled period
// - Lockout ignores triggers until delay expires
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
module rfc_core
    import rfc_pkg::*;
#(
    parameter bit ENHANCED = 1'b0,
    parameter int CW = 32,
    parameter int MS_CYCLES = CLK_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_a,
    input wire logic trig_b,
    input wire logic trig_c,
    input wire logic level_ok_c,
    output logic irq,
    output logic gate_open
);
    // Gate-time resolution units per clock
    localparam int STEP = CLK_PS / (ENHANCED ? RES_ENH_PS : RES_BASIC_PS);
    localparam int TGW = 48;
    localparam logic [15:0] TMO_MIN = ENHANCED ? TMO_MIN_ENH_MS : TMO_MIN_BASIC_MS;
    // The timeout register keeps the word as written; the limits apply only
    // where the no-trigger timer is compared, so software reads back its own value

    // Refuse widths the logic cannot serve
    if (CW < 8 || CW > 32) begin : g_chk_cw
        $error("rfc_core: CW must be 8..32");
    end
    if (MS_CYCLES < 1) begin : g_chk_ms
        $error("rfc_core: MS_CYCLES must be positive");
    end

    // All state of the block
    // One packed word, so reset and the clock update stay in one place;
    // every field is recomputed from next_s on each clock
    typedef struct packed {
        logic [2:0] sa; // Input A synchroniser
        logic [2:0] sb; // Input B synchroniser
        logic [2:0] sc; // Input C synchroniser
        logic [2:0] sl; // Level detector synchroniser
        logic [3:0] lv; // Agreed levels of A, B, C and level detector
        logic [CTL_W-1:0] ctrl; // Control word
        logic [31:0] meas_time; // Set measurement time, clocks
        logic [15:0] tmo_ms; // Timeout in ms
        logic [31:0] lockout; // Lockout delay, clocks
        logic [1:0] irq_stat; // Sticky events
        logic [1:0] irq_mask; // Event enables
        logic [31:0] rdata; // Read data
        rfc_state_t st; // Measurement state
        logic [5:0] psc; // Prescaler count
        logic [31:0] lock_cnt; // Lockout remaining
        logic [31:0] mt_cnt; // Elapsed measurement time
        logic [31:0] ms_div; // Millisecond divider
        logic [15:0] ms_cnt; // Ms since last prescaled event
        logic [CW-1:0] n; // Cycles in gate
        logic [TGW-1:0] tg; // Gate duration
        logic [CW-1:0] res_raw; // Last raw cycle count
        logic [CW-1:0] res_n; // Last scaled cycle count
        logic [TGW-1:0] res_tg; // Last gate duration
        logic valid; // A result is held
        logic nosig; // Last attempt timed out
    } rfc_state_s_t;

    rfc_state_s_t s;
    rfc_state_s_t next_s;

    // Division factor for the selected function
    // Negative slope on input A skips the prescaler, so a single-cycle
    // aperture can cover exactly one input period
    function automatic logic [5:0] div_factor(input logic [1:0] fn, input logic neg);
        if (fn == RFC_FN_A && !neg) begin
            div_factor = ENHANCED ? DIV_A_ENH : DIV_A_BASIC;
        end else if (fn == RFC_FN_C) begin
            div_factor = ENHANCED ? DIV_C_ENH : DIV_C_BASIC;
        end else begin
            div_factor = DIV_ONE;
        end
    endfunction

    // Clamp programmed timeout into the allowed range
    // Values outside the range would let the timer fire too early or too late
    function automatic logic [15:0] tmo_clamp(input logic [15:0] v);
        if (v < TMO_MIN) begin
            tmo_clamp = TMO_MIN;
        end else if (v > TMO_MAX_MS) begin
            tmo_clamp = TMO_MAX_MS;
        end else begin
            tmo_clamp = v;
        end
    endfunction

    // Register read multiplexer
    // Status word: [0]busy [1]gate [2]valid [3]no signal [9:4]active factor
    // Results only change at the end of a measurement, so low and high stay paired
    function automatic logic [31:0] rd_mux(input rfc_state_s_t q, input logic [7:0] a);
        case (a)
            OFS_CTRL: rd_mux = 32'(q.ctrl);
            OFS_MEAS_TIME: rd_mux = q.meas_time;
            OFS_TIMEOUT: rd_mux = 32'(q.tmo_ms);
            OFS_LOCKOUT: rd_mux = q.lockout;
            OFS_STATUS: rd_mux = {22'h0, div_factor(q.ctrl[CTL_FUNC +: 2], q.ctrl[CTL_NEG]),
                q.nosig, q.valid, q.st == RFC_GATE, q.st != RFC_IDLE};
            OFS_RES_N: rd_mux = 32'(q.res_n);
            OFS_RES_TG_LO: rd_mux = q.res_tg[31:0];
            OFS_RES_TG_HI: rd_mux = 32'(q.res_tg[TGW-1:32]);
            OFS_IRQ_STAT: rd_mux = 32'(q.irq_stat);
            OFS_IRQ_MASK: rd_mux = 32'(q.irq_mask);
            OFS_RES_RAW: rd_mux = 32'(q.res_raw);
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    // Known register offsets
    // Unmapped offsets answer with an error and read as zero
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            OFS_CTRL, OFS_MEAS_TIME, OFS_TIMEOUT, OFS_LOCKOUT, OFS_STATUS,
            OFS_RES_N, OFS_RES_TG_LO, OFS_RES_TG_HI, OFS_IRQ_STAT,
            OFS_IRQ_MASK, OFS_RES_RAW: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Helper signals for the next-state logic
    logic setup; // APB setup cycle
    logic wr; // Write takes effect
    logic rd_clr; // Read of interrupt status
    logic ev_a_r; // Synchronised A rising edge
    logic ev_a_f; // Synchronised A falling edge
    logic ev_b; // Synchronised B rising edge
    logic ev_c; // Synchronised C rising edge
    logic lvl_ok; // High-band level adequate
    logic raw_ev; // Selected input trigger
    logic acc_ev; // Trigger after lockout
    logic pevt; // Prescaled trigger
    logic [5:0] d; // Active division factor
    logic ms_tick; // One-ms enable pulse
    logic elapsed; // Measurement time reached
    logic tmo_hit; // Timeout reached
    logic [1:0] ev; // Interrupt events this cycle

    // Next-state logic
    // Every field starts from its current value; only the branches below move it
    // Helper signals are assigned on every path to keep this process free of latches
    always_comb begin
        next_s = s;
        setup = psel && !penable;
        wr = psel && penable && pwrite;
        rd_clr = psel && penable && !pwrite && paddr == OFS_IRQ_STAT;
        ev = 2'b00;

        // Three-stage synchronisers; a new level is taken once stages 2 and 3 agree
        // A glitch that reaches only one stage never moves the agreed level
        next_s.sa = {s.sa[1:0], trig_a};
        next_s.sb = {s.sb[1:0], trig_b};
        next_s.sc = {s.sc[1:0], trig_c};
        next_s.sl = {s.sl[1:0], level_ok_c};
        if (s.sa[1] == s.sa[2]) begin
            next_s.lv[0] = s.sa[2];
        end
        if (s.sb[1] == s.sb[2]) begin
            next_s.lv[1] = s.sb[2];
        end
        if (s.sc[1] == s.sc[2]) begin
            next_s.lv[2] = s.sc[2];
        end
        if (s.sl[1] == s.sl[2]) begin
            next_s.lv[3] = s.sl[2];
        end
        // Edges are changes of the agreed level; reset leaves it low like idle pins
        ev_a_r = s.sa[1] && s.sa[2] && !s.lv[0];
        ev_a_f = !s.sa[1] && !s.sa[2] && s.lv[0];
        ev_b = s.sb[1] && s.sb[2] && !s.lv[1];
        ev_c = s.sc[1] && s.sc[2] && !s.lv[2];
        lvl_ok = s.lv[3];

        // Trigger source selection
        // Other function codes fall back to input A
        // High band edges pass only while the level detector reports enough signal
        case (s.ctrl[CTL_FUNC +: 2])
            RFC_FN_A: raw_ev = s.ctrl[CTL_NEG] ? ev_a_f : ev_a_r;
            RFC_FN_B: raw_ev = ev_b;
            RFC_FN_C: raw_ev = ev_c && lvl_ok;
            default: raw_ev = s.ctrl[CTL_NEG] ? ev_a_f : ev_a_r;
        endcase

        // Trigger lockout
        // A lockout of zero cycles, or lockout off, lets every trigger through
        // The reload on an accepted trigger wins over the countdown
        acc_ev = raw_ev && (s.lock_cnt == 32'h0000_0000 || !s.ctrl[CTL_LOCK]);
        if (acc_ev && s.ctrl[CTL_LOCK]) begin
            next_s.lock_cnt = s.lockout;
        end else if (s.lock_cnt != 32'h0000_0000) begin
            next_s.lock_cnt = s.lock_cnt - 32'h0000_0001;
        end

        // Prescaler: one output event per d accepted triggers
        // The prescaler free-runs and is not cleared at arming, so the first
        // event phase is arbitrary; a smaller factor takes effect at once
        d = div_factor(s.ctrl[CTL_FUNC +: 2], s.ctrl[CTL_NEG]);
        pevt = acc_ev && (s.psc >= d - DIV_ONE);
        if (pevt) begin
            next_s.psc = 6'd0;
        end else if (acc_ev) begin
            next_s.psc = s.psc + 6'd1;
        end

        // Millisecond divider and no-trigger timer
        // The divider runs freely; its phase only shifts the timeout by under a ms
        // The timer restarts on every prescaled event and while idle
        ms_tick = s.ms_div >= 32'(MS_CYCLES - 1);
        next_s.ms_div = ms_tick ? 32'h0000_0000 : s.ms_div + 32'h0000_0001;
        if (pevt || s.st == RFC_IDLE) begin
            next_s.ms_cnt = 16'h0000;
        end else if (ms_tick && s.ms_cnt != 16'hFFFF) begin
            next_s.ms_cnt = s.ms_cnt + 16'h0001;
        end
        tmo_hit = s.ctrl[CTL_TMO] && !pevt && s.ms_cnt >= tmo_clamp(s.tmo_ms);

        // Measurement time runs from the start of the attempt
        // Counting stops once elapsed; the gate then waits for its closing event
        elapsed = s.mt_cnt >= s.meas_time;
        if (s.st == RFC_IDLE || s.st == RFC_DONE) begin
            next_s.mt_cnt = 32'h0000_0000;
        end else if (!elapsed) begin
            next_s.mt_cnt = s.mt_cnt + 32'h0000_0001;
        end

        // Measurement sequencer
        // Idle waits for run; armed waits for the opening event; the gate closes
        // on the first event after the set time, or the next one in single mode;
        // done lasts one clock and re-arms while run stays set
        case (s.st)
            RFC_IDLE: begin
                if (s.ctrl[CTL_RUN]) begin
                    next_s.st = RFC_ARMED;
                end
            end
            RFC_ARMED: begin
                if (tmo_hit) begin
                    next_s.st = RFC_IDLE;
                    next_s.nosig = 1'b1;
                    ev[IRQ_NOSIG] = 1'b1;
                end else if (pevt) begin
                    next_s.st = RFC_GATE;
                    next_s.n = '0;
                    next_s.tg = '0;
                end else if (!s.ctrl[CTL_RUN]) begin
                    next_s.st = RFC_IDLE;
                end
            end
            RFC_GATE: begin
                next_s.tg = s.tg + TGW'(STEP);
                if (tmo_hit) begin
                    next_s.st = RFC_IDLE;
                    next_s.nosig = 1'b1;
                    ev[IRQ_NOSIG] = 1'b1;
                end else if (pevt) begin
                    next_s.n = s.n + CW'(1);
                    if (elapsed || s.ctrl[CTL_SINGLE]) begin
                        next_s.st = RFC_DONE;
                        next_s.res_raw = s.n + CW'(1);
                        next_s.res_n = CW'((s.n + CW'(1)) * CW'(d));
                        next_s.res_tg = s.tg + TGW'(STEP);
                        next_s.valid = 1'b1;
                        next_s.nosig = 1'b0;
                        ev[IRQ_DONE] = 1'b1;
                    end
                end
            end
            RFC_DONE: begin
                next_s.st = s.ctrl[CTL_RUN] ? RFC_ARMED : RFC_IDLE;
            end
            default: next_s.st = RFC_IDLE;
        endcase

        // Register writes
        // Read-only and unmapped offsets ignore writes
        if (wr) begin
            case (paddr)
                OFS_CTRL: next_s.ctrl = pwdata[CTL_W-1:0];
                OFS_MEAS_TIME: next_s.meas_time = pwdata;
                OFS_TIMEOUT: next_s.tmo_ms = pwdata[15:0];
                OFS_LOCKOUT: next_s.lockout = pwdata;
                OFS_IRQ_MASK: next_s.irq_mask = pwdata[1:0];
                default: next_s.ctrl = s.ctrl;
            endcase
        end

        // Sticky events, set wins over read clear
        next_s.irq_stat = ev | (rd_clr ? 2'b00 : s.irq_stat);

        // Read data captured in the setup cycle
        // prdata then stands until the next read setup cycle
        if (setup && !pwrite) begin
            next_s.rdata = rd_mux(s, paddr);
        end
    end

    // State register
    // Asynchronous reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= RFC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    // Handshake outputs combinational, zero wait states
    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign irq = |(s.irq_stat & s.irq_mask);
    assign gate_open = s.st == RFC_GATE;
endmodule

// ---- src/rfc_pkg.sv ----
// Purpose: Constants, register map and state codes of the reciprocal counter.
// Assumes: APB slave with 32-bit data and 50 ns pclk.
// Notes: Byte offsets, one aligned word per register.
package rfc_pkg;
    // Clock period and gate-time resolutions in picoseconds
    localparam int CLK_PS = 50000;
    localparam int RES_BASIC_PS = 250;
    localparam int RES_ENH_PS = 50;
    // Timeout limits in milliseconds, clock rate in kHz
    localparam logic [15:0] TMO_MIN_BASIC_MS = 16'd100;
    localparam logic [15:0] TMO_MIN_ENH_MS = 16'd64;
    localparam logic [15:0] TMO_MAX_MS = 16'd25500;
    localparam int CLK_KHZ = 20000;
    // Division factors
    localparam logic [5:0] DIV_ONE = 6'd1;
    localparam logic [5:0] DIV_A_BASIC = 6'd2;
    localparam logic [5:0] DIV_A_ENH = 6'd4;
    localparam logic [5:0] DIV_C_BASIC = 6'd16;
    localparam logic [5:0] DIV_C_ENH = 6'd32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MEAS_TIME = 8'h04;
    localparam logic [7:0] OFS_TIMEOUT = 8'h08;
    localparam logic [7:0] OFS_LOCKOUT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RES_N = 8'h14;
    localparam logic [7:0] OFS_RES_TG_LO = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_RES_RAW = 8'h24;
    localparam logic [7:0] OFS_RES_TG_HI = 8'h28;
    // Control field positions
    localparam int CTL_RUN = 0;
    localparam int CTL_FUNC = 1;
    localparam int CTL_NEG = 3;
    localparam int CTL_SINGLE = 4;
    localparam int CTL_LOCK = 5;
    localparam int CTL_TMO = 6;
    localparam int CTL_W = 7;
    // Interrupt bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_NOSIG = 1;
    // Function codes
    typedef enum logic [1:0] {
        RFC_FN_A = 2'd0,
        RFC_FN_B = 2'd1,
        RFC_FN_C = 2'd2,
        RFC_FN_OTHER = 2'd3
    } rfc_func_t;
    // Measurement states, one-hot
    typedef enum logic [3:0] {
        RFC_IDLE = 4'b0001,
        RFC_ARMED = 4'b0010,
        RFC_GATE = 4'b0100,
        RFC_DONE = 4'b1000
    } rfc_state_t;
endpackage

// ---- tb/rfc_trig_src.sv ----
// Purpose: Conditioned trigger source feeding the counter inputs.
// Assumes: Square wave, period given in pclk cycles.
// Notes: Held low while disabled, so no stray edges between runs.
`timescale 1ns/100ps
module rfc_trig_src (
    input wire logic pclk,
    input wire logic en,
    input wire logic [7:0] period,
    output logic trig = 1'b0
);
    logic [7:0] ph = 8'h00; // Phase within the period
    // Half high, half low; bursts outlast factor times period
    always @(posedge pclk) begin
        ph <= (!en || ph >= period - 8'h01) ? 8'h00 : ph + 8'h01;
        trig <= en && (ph < (period >> 1));
    end
endmodule

// ---- tb/rfc_core_sva.sv ----
// Purpose: Port checker for the reciprocal counter.
// Assumes: Trigger edges recognised a few clocks after the pin moves.
// Notes: Bound to the core from the testbench top.
`timescale 1ns/100ps
module rfc_core_sva
    import rfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trig_a,
    input wire logic trig_b,
    input wire logic trig_c,
    input wire logic irq,
    input wire logic gate_open
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] trig_q; // Trigger levels one cycle ago
    logic [3:0] since; // Cycles since a trigger pin moved
    logic acc; // APB access phase
    assign acc = psel && penable;
    // Saturating age of the last trigger pin change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= 3'h0;
            since <= 4'hF;
        end else begin
            trig_q <= {trig_a, trig_b, trig_c};
            if (trig_q != {trig_a, trig_b, trig_c}) since <= 4'h0;
            else if (since != 4'hF) since <= since + 4'h1;
        end
    end
    AST_OPEN_ON_EDGE: assert property ($rose(gate_open) |-> since <= 4'h8)
        else $error("gate opened without a trigger edge");
    AST_CLOSE_ON_EDGE: assert property ($fell(gate_open) |-> since <= 4'h8)
        else $error("gate closed without a trigger edge");
    AST_GATE_MIN: assert property ($rose(gate_open) |-> gate_open [*4])
        else $error("gate shorter than one input period");
    AST_DONE_AT_CLOSE: assert property ($rose(irq) && !$past(acc && pwrite)
        |-> $fell(gate_open) || !$past(gate_open))
        else $error("interrupt rose inside an open gate");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(acc))
        else $error("interrupt dropped without a bus access");
    AST_READ_CLEAR: assert property (acc && !pwrite && paddr == OFS_IRQ_STAT
        && !gate_open |=> !irq)
        else $error("interrupt status not cleared by read");
    AST_READY: assert property (acc |-> pready)
        else $error("access phase without ready");
    AST_ERR_ZERO: assert property (pslverr |-> acc && (pwrite || prdata == 32'h0))
        else $error("error response outside access or with data");
    COV_GATE: cover property ($fell(gate_open));
    COV_IRQ: cover property ($rose(irq));
    COV_ERR: cover property (pslverr);
endmodule

// ---- tb/test_rfc_core.sv ----
// Purpose: Directed bench for the reciprocal counter over APB.
// Assumes: Basic variant, 10 clocks per ms, trigger period 8 clocks.
// Notes: Gate time expected as clocks times 200 units.
`timescale 1ns/100ps
module test_rfc_core;
    import rfc_pkg::*;
    localparam int P = 8; // Trigger period in clocks
    localparam int STEP = 200; // Gate time units per clock
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, raw, resn, tg;
    logic pready, pslverr, irq, gate_open, trig, err;
    logic src_en = 1'b0; // Trigger source running
    logic level_ok_c = 1'b1; // High band level detector
    logic [31:0] mode [5] = '{32'h10, 32'h18, 32'h12, 32'h14, 32'h16};
    logic [31:0] fac [5] = '{32'h2, 32'h1, 32'h1, 32'h10, 32'h1};
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int waited = 0; // Cycles measure spent waiting for the interrupt
    always #25 pclk = ~pclk;
    rfc_core #(.ENHANCED(1'b0), .CW(32), .MS_CYCLES(10)) dut_u (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_a(trig), .trig_b(trig), .trig_c(trig),
        .level_ok_c(level_ok_c), .irq(irq), .gate_open(gate_open));
    rfc_trig_src src_u (.pclk(pclk), .en(src_en), .period(8'(P)), .trig(trig));
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_gate(input logic v);
        while (gate_open !== v) begin
            @(posedge pclk);
        end
    endtask
    // Run until the interrupt, stop, leave the interrupt status word in rd
    task automatic measure(input logic [31:0] ctrl);
        int n;
        n = 0;
        apb(1'b1, OFS_CTRL, ctrl | 32'h1);
        while (irq !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        waited = n;
        apb(1'b1, OFS_CTRL, ctrl);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
    endtask
    task automatic get_res();
        apb(1'b0, OFS_RES_RAW, 32'h0);
        raw = rd;
        apb(1'b0, OFS_RES_N, 32'h0);
        resn = rd;
        apb(1'b0, OFS_RES_TG_LO, 32'h0);
        tg = rd;
        apb(1'b0, OFS_RES_TG_HI, 32'h0);
        chk("tg_hi", 32'h0, rd);
        chk("gate_shut", 32'h0, {31'h0, gate_open});
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_rst", 32'h0, rd);
        apb(1'b0, 8'h3C, 32'h0);
        chk("err_unmapped", 32'h1, {31'h0, err});
        chk("pready", 32'h1, {31'h0, pready});
        src_en <= 1'b1;
        apb(1'b1, OFS_MEAS_TIME, 32'h28);
        // Averaging run on A, interrupt still masked
        apb(1'b1, OFS_CTRL, 32'h1);
        wait_gate(1'b1);
        wait_gate(1'b0);
        apb(1'b1, OFS_CTRL, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_IRQ_MASK, 32'h3);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h1, rd);
        chk("irq_clear", 32'h0, {31'h0, irq});
        get_res();
        chk("raw_range", 32'h1, {31'h0, raw == 32'h2 || raw == 32'h3});
        chk("res_n", raw * 32'h2, resn);
        chk("tg", raw * 32'h2 * P * STEP, tg);
        // Single cycle in every function
        for (int i = 0; i < 5; i++) begin
            measure(mode[i]);
            chk("done", 32'h1, rd);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("factor", fac[i], (rd >> 4) & 32'h3F);
            get_res();
            chk("raw_single", 32'h1, raw);
            chk("res_n_single", fac[i], resn);
            chk("tg_single", fac[i] * P * STEP, tg);
        end
        // Weak high band, lowered early so its synchroniser settles before arming
        level_ok_c <= 1'b0;
        // The register keeps the written word; the clamp acts on the timer
        apb(1'b1, OFS_TIMEOUT, 32'h7530);
        apb(1'b0, OFS_TIMEOUT, 32'h0);
        chk("tmo_word_hi", 32'h7530, rd);
        apb(1'b1, OFS_TIMEOUT, 32'h5);
        apb(1'b0, OFS_TIMEOUT, 32'h0);
        chk("tmo_word_lo", 32'h5, rd);
        // No events reach the gate; the 100 ms floor (1000 clocks here) ends it
        measure(32'h44);
        chk("nosig", 32'h2, rd);
        chk("tmo_floor", 32'h1, {31'h0, waited >= 32'h3DE && waited <= 32'h3F2});
        get_res();
        chk("raw_held", 32'h1, raw);
        chk("tg_held", P * STEP, tg);
        level_ok_c <= 1'b1;
        // Lockout of 12 clocks, 150 percent of the 8 clock trigger period, skips every other edge
        apb(1'b1, OFS_LOCKOUT, 32'hC);
        measure(32'h32);
        get_res();
        chk("tg_lockout", 2 * P * STEP, tg);
        final_report();
    end
endmodule
bind rfc_core rfc_core_sva chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_a(trig_a), .trig_b(trig_b),
    .trig_c(trig_c), .irq(irq), .gate_open(gate_open));
